// ===== hdl/flash_cmd_map.vh
/*
 * Opcodes, phase lengths and link constants for the serial flash command host.
 * Assumes a flash device on the far side, clocked by the host-made serial clock.
 */
// Functional notes
// - Write enable 06h, disable 04h, volatile enable 50h: lone 8-clock opcode.
// - Block lock 36h and unlock 39h: opcode plus three address bytes.
// - Global lock 7Eh and unlock 98h: opcode only, 8 clocks.
// - OTP program 9Bh: three address bytes, then 1 to 128 host bytes.
// - Status read 65h: one address byte, one dummy, one returned byte, or up to 6 when the address is 01h.
// - Status write 01h, 31h, 11h: opcode then one host byte.
// - Status write 71h: one address byte then one host byte.
// - Status lock 6Fh: opcode then two host bytes, 24 clocks.
// - Power-down B9h and 79h: opcode only.
// - Software reset: frame 66h then frame 99h.
// - Terminate F0h: opcode then one host byte.
// - Status interrupt 25h: variable dummy bytes, no data.
// - Read-modify-write 0Ah: address then host bytes; EFh opcode only.
// - Lines per phase: one means io0 out and io1 in; quad puts address, dummy and data on io0 to io3.
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
`define OP_WREN      8'h06
`define OP_WRDI      8'h04
`define OP_VWREN     8'h50
`define OP_BLK_LOCK  8'h36
`define OP_BLK_ULOCK 8'h39
`define OP_BLK_QRYA  8'h3C
`define OP_BLK_QRYB  8'h3D
`define OP_GLB_LOCK  8'h7E
`define OP_GLB_ULOCK 8'h98
`define OP_OTP_PROG  8'h9B
`define OP_OTP_READ  8'h4B
`define OP_SR1_RD    8'h05
`define OP_SR2_RD    8'h35
`define OP_SR3_RD    8'h15
`define OP_SRX_RD    8'h65
`define OP_SR1_WR    8'h01
`define OP_SR2_WR    8'h31
`define OP_SR3_WR    8'h11
`define OP_SRX_WR    8'h71
`define OP_SR_LOCK   8'h6F
`define OP_DPD       8'hB9
`define OP_UDPD      8'h79
`define OP_RESUME    8'hAB
`define OP_RST_EN    8'h66
`define OP_RST       8'h99
`define OP_TERM      8'hF0
`define OP_ID_SPI    8'h90
`define OP_ID_QUAD   8'h94
`define OP_JEDEC     8'h9F
`define OP_ASI       8'h25
`define OP_RMW       8'h0A
`define OP_LBD       8'hEF
`define OP_SFDP      8'h5A
`define OTP_MAX      8'h80
`define SRX_MAX      8'h06
`define JEDEC_LEN    8'h05
`define ID_LEN       8'h02
`define SCK_HALF     4'h8
`define GAP_CYCLES   4'h8
`endif

// ===== hdl/flash_cmd_host.v
/*
 * Host controller framing protection, status, power, reset and ID commands.
 * Assumes a flash device on cs_n/sck/si/so; io pins resolved in the bench.
 */
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module flash_cmd_host (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Command request
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_op,
    input  wire [23:0] cmd_addr,
    input  wire [7:0]  cmd_len,
    input  wire [7:0]  cmd_dummy,
    output reg         cmd_ready,
    // Write data stream
    input  wire [7:0]  wr_data,
    output reg         wr_take,
    // Read data stream
    output reg  [7:0]  rd_data,
    output reg         rd_valid,
    output reg         busy_level,
    output reg         done,
    output reg         bad_cmd,
    // Flash pins
    output reg         cs_n,
    output reg         sck,
    output reg         io0_out,
    output reg         io0_oe,
    input  wire        io0_in,
    output reg         io1_out,
    output reg         io1_oe,
    input  wire        io1_in,
    output reg         io2_out,
    output reg         io2_oe,
    input  wire        io2_in,
    output reg         io3_out,
    output reg         io3_oe,
    input  wire        io3_in
);
////////////////////////////////////////////////////////////////////////////////
localparam [5:0] ST_IDLE = 6'b00_0001;
localparam [5:0] ST_CMD  = 6'b00_0010;
localparam [5:0] ST_ADDR = 6'b00_0100;
localparam [5:0] ST_DUM  = 6'b00_1000;
localparam [5:0] ST_DATA = 6'b01_0000;
localparam [5:0] ST_GAP  = 6'b10_0000;
// Frame shape: addr bytes, dummy bytes, data bytes, read, quad
function [19:0] shape;
    input [7:0] op;
    input [7:0] len;
    input [7:0] dum;
    input [23:0] adr;
    begin
        case (op)
            `OP_WREN, `OP_WRDI, `OP_VWREN, `OP_GLB_LOCK, `OP_GLB_ULOCK,
            `OP_DPD, `OP_UDPD, `OP_RST_EN, `OP_RST, `OP_LBD:
                shape = 20'h0_0000;
            `OP_BLK_LOCK, `OP_BLK_ULOCK:
                shape = {2'd3, 8'd0, 8'd0, 2'b00};
            `OP_BLK_QRYA, `OP_BLK_QRYB:
                shape = {2'd3, 8'd0, 8'd1, 2'b10};
            `OP_OTP_PROG:
                shape = {2'd3, 8'd0, (len > `OTP_MAX) ? `OTP_MAX : len, 2'b00};
            `OP_OTP_READ:
                shape = {2'd3, 8'd1, (len > `OTP_MAX) ? `OTP_MAX : len, 2'b10};
            `OP_SR1_RD, `OP_SR2_RD, `OP_SR3_RD:
                shape = {2'd0, 8'd0, 8'd1, 2'b10};
            `OP_SRX_RD:
                shape = {2'd1, 8'd1, (adr[7:0] == 8'h01 && len > 8'd1) ?
                    ((len > `SRX_MAX) ? `SRX_MAX : len) : 8'd1, 2'b10};
            `OP_SR1_WR, `OP_SR2_WR, `OP_SR3_WR, `OP_TERM:
                shape = {2'd0, 8'd0, 8'd1, 2'b00};
            `OP_SRX_WR:
                shape = {2'd1, 8'd0, 8'd1, 2'b00};
            `OP_SR_LOCK:
                shape = {2'd0, 8'd0, 8'd2, 2'b00};
            `OP_RESUME:
                shape = (len == 8'd0) ? 20'h0_0000 : {2'd3, 8'd0, 8'd1, 2'b10};
            `OP_ID_SPI:
                shape = {2'd3, 8'd0, `ID_LEN, 2'b10};
            `OP_ID_QUAD:
                shape = {2'd3, 8'd1, `ID_LEN, 2'b11};
            `OP_JEDEC:
                shape = {2'd0, 8'd0, `JEDEC_LEN, 2'b10};
            `OP_ASI:
                shape = {2'd0, dum, 8'd0, 2'b00};
            `OP_RMW:
                shape = {2'd3, 8'd0, len, 2'b00};
            `OP_SFDP:
                shape = {2'd3, 8'd1, len, 2'b10};
            default:
                shape = 20'hF_FFFF;
        endcase
    end
endfunction
////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [3:0] io_meta;
reg [3:0] io_sync;
always @(posedge clk) begin
    if (!rst_n) begin
        io_meta <= 4'h0;
        io_sync <= 4'h0;
    end else begin
        io_meta <= {io3_in, io2_in, io1_in, io0_in};
        io_sync <= io_meta;
    end
end
////////////////////////////////////////////////////////////////////////////////
reg [5:0]  state;
reg [19:0] fr;
reg [7:0]  op;
reg [23:0] addr;
reg [7:0]  sh;
reg [7:0]  byte_left;
reg [3:0]  bit_left;
reg [3:0]  div;
reg [3:0]  gap;
wire       quad   = fr[0];
wire       is_rd  = fr[1];
wire [7:0] n_dat  = fr[9:2];
wire [7:0] n_dum  = fr[17:10];
wire [1:0] n_adr  = fr[19:18];
wire       edge_r = sck == 1'b0 && div == 4'h0;
wire       edge_f = sck == 1'b1 && div == 4'h0;
wire       wide   = quad && state != ST_CMD;
wire       last_b = bit_left == 4'h1;
wire       rd_ph  = state == ST_DATA && is_rd;
wire [19:0] next_fr = shape(cmd_op, cmd_len, cmd_dummy, cmd_addr);
always @(posedge clk) begin
    if (!rst_n) begin
        state <= ST_IDLE; fr <= 20'h0_0000; op <= 8'h00; addr <= 24'h00_0000;
        sh <= 8'h00; byte_left <= 8'h00; bit_left <= 4'h0; div <= 4'h0;
        gap <= 4'h0; cmd_ready <= 1'b1; wr_take <= 1'b0; rd_data <= 8'h00;
        rd_valid <= 1'b0; busy_level <= 1'b0; done <= 1'b0; bad_cmd <= 1'b0;
        cs_n <= 1'b1; sck <= 1'b0; io0_out <= 1'b0; io0_oe <= 1'b0;
        io1_out <= 1'b0; io1_oe <= 1'b0; io2_out <= 1'b0; io2_oe <= 1'b0;
        io3_out <= 1'b0; io3_oe <= 1'b0;
    end else begin
        wr_take <= 1'b0;
        rd_valid <= 1'b0;
        done <= 1'b0;
        bad_cmd <= 1'b0;
        if (state != ST_IDLE && state != ST_GAP)
            div <= (div == 4'h0) ? `SCK_HALF - 4'h1 : div - 4'h1;
        case (state)
            ST_IDLE: begin
                if (cmd_valid) begin
                    cmd_ready <= 1'b0;
                    if (next_fr == 20'hF_FFFF) begin
                        bad_cmd <= 1'b1;
                        done <= 1'b1;
                        gap <= `GAP_CYCLES;
                        state <= ST_GAP;
                    end else begin
                        fr <= next_fr; op <= cmd_op; addr <= cmd_addr;
                        sh <= cmd_op; bit_left <= 4'h8; div <= `SCK_HALF - 4'h1;
                        cs_n <= 1'b0; io0_oe <= 1'b1; io0_out <= cmd_op[7];
                        state <= ST_CMD;
                    end
                end
            end
            ST_CMD, ST_ADDR, ST_DUM, ST_DATA: begin
                if (edge_r) begin
                    sck <= 1'b1;
                    if (rd_ph)
                        sh <= wide ? {sh[3:0], io_sync} : {sh[6:0], io_sync[1]};
                    if (op == `OP_ASI && state == ST_DUM)
                        busy_level <= io_sync[1];
                end else if (edge_f) begin
                    sck <= 1'b0;
                    if (last_b || (wide && bit_left == 4'h4)) begin
                        if (rd_ph) begin
                            rd_data <= sh;
                            rd_valid <= 1'b1;
                        end
                        if (state == ST_CMD && n_adr != 2'd0) begin
                            state <= ST_ADDR; byte_left <= {6'd0, n_adr};
                            sh <= cmd_addr_byte(addr, n_adr);
                        end else if (state == ST_ADDR && byte_left > 8'd1) begin
                            byte_left <= byte_left - 8'd1;
                            sh <= cmd_addr_byte(addr, byte_left[1:0] - 2'd1);
                        end else if ((state == ST_CMD || state == ST_ADDR) && n_dum != 8'd0) begin
                            state <= ST_DUM; byte_left <= n_dum; sh <= 8'h00;
                        end else if (state == ST_DUM && byte_left > 8'd1) begin
                            byte_left <= byte_left - 8'd1;
                        end else if (state != ST_DATA && n_dat != 8'd0) begin
                            state <= ST_DATA; byte_left <= n_dat;
                            sh <= wr_data; wr_take <= !is_rd;
                        end else if (state == ST_DATA && byte_left > 8'd1) begin
                            byte_left <= byte_left - 8'd1;
                            sh <= is_rd ? 8'h00 : wr_data; wr_take <= !is_rd;
                        end else begin
                            state <= ST_GAP; gap <= `GAP_CYCLES; cs_n <= 1'b1;
                            done <= 1'b1;
                        end
                        bit_left <= 4'h8;
                    end else begin
                        bit_left <= bit_left - (wide ? 4'h4 : 4'h1);
                        if (!rd_ph)
                            sh <= wide ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
                    end
                end
            end
            ST_GAP: begin
                // each reset step ends its own frame
                gap <= gap - 4'h1;
                if (gap == 4'h0) begin
                    state <= ST_IDLE; cmd_ready <= 1'b1;
                end
            end
            default: state <= ST_IDLE;
        endcase
        // Pin drive follows shift register and phase
        if (state != ST_IDLE && state != ST_GAP) begin
            io0_oe <= !(rd_ph || (state == ST_DUM && (quad || op == `OP_ASI)));
            io1_oe <= wide && !rd_ph && state != ST_DUM;
            io2_oe <= wide && !rd_ph && state != ST_DUM;
            io3_oe <= wide && !rd_ph && state != ST_DUM;
        end
        if (state == ST_GAP) begin
            io0_oe <= 1'b0; io1_oe <= 1'b0; io2_oe <= 1'b0; io3_oe <= 1'b0;
        end
        if (state != ST_IDLE) begin
            io0_out <= wide ? sh[4] : sh[7];
            io1_out <= sh[5];
            io2_out <= sh[6];
            io3_out <= sh[7];
        end
    end
end
// Address byte selector, index 3 is the most significant
function [7:0] cmd_addr_byte;
    input [23:0] a;
    input [1:0]  idx;
    begin
        case (idx)
            2'd3: cmd_addr_byte = a[23:16];
            2'd2: cmd_addr_byte = a[15:8];
            default: cmd_addr_byte = a[7:0];
        endcase
    end
endfunction
endmodule

// ===== testbench/flash_cmd_host_assertions.sv
/* Port assertions for the flash command host.
   Bound into flash_cmd_host below; sees its ports only. */
`timescale 1ns/100ps
module flash_cmd_host_chk (
    // Clock and reset
    input logic       clk,
    input logic       rst_n,
    // Request side
    input logic       cmd_valid,
    input logic [7:0] cmd_op,
    input logic       cmd_ready,
    input logic       wr_take,
    input logic       done,
    input logic       bad_cmd,
    // Pins
    input logic       cs_n,
    input logic       sck,
    input logic       io0_oe,
    input logic       io2_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_bad; bad_cmd |-> cs_n && $past(cs_n); endproperty
    property p_frame; cmd_valid && cmd_ready && cmd_op == 8'h06 |=> ##[0:1] !cs_n; endproperty
    property p_idle; cs_n |-> !sck; endproperty
    property p_half; $rose(sck) |-> sck [*8]; endproperty
    property p_done; done |-> cs_n; endproperty
    property p_gap; done |=> !cmd_ready [*8]; endproperty
    property p_take; wr_take |-> !cs_n; endproperty
    property p_quad; io2_oe |-> !cs_n && io0_oe; endproperty
    a_bad: assert property (p_bad) else $error("frame on unknown op");
    a_frame: assert property (p_frame) else $error("no frame");
    a_idle: assert property (p_idle) else $error("sck not idle");
    a_half: assert property (p_half) else $error("sck high time");
    a_done: assert property (p_done) else $error("done in frame");
    a_gap: assert property (p_gap) else $error("frames too close");
    a_take: assert property (p_take) else $error("take outside frame");
    a_quad: assert property (p_quad) else $error("quad lines out of frame");
    c_done: cover property (done);
    c_bad: cover property (bad_cmd);
    c_quad: cover property (io2_oe);
endmodule
bind flash_cmd_host flash_cmd_host_chk u_chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_ready(cmd_ready), .wr_take(wr_take), .done(done),
    .bad_cmd(bad_cmd), .cs_n(cs_n), .sck(sck), .io0_oe(io0_oe), .io2_oe(io2_oe));

// ===== testbench/flash_dev_model.sv
/* Behavioural serial flash, mode 0.
   Samples io0 on sck rise, drives io1 on sck fall; returns A0h+n. */
`timescale 1ns/100ps
module flash_dev_model (
    // Link pins
    input  wire cs_n,
    input  wire sck,
    input  wire io0,
    output reg  io1
);
    reg [7:0] op;
    reg [7:0] b;
    integer   n;
    integer   k;
    function integer lead(input [7:0] o);
        case (o)
            8'h05, 8'h35, 8'h15, 8'h9F: lead = 8;
            8'h65:                      lead = 24;
            8'h3C, 8'h3D, 8'h90, 8'hAB: lead = 32;
            8'h4B, 8'h5A:               lead = 40;
            default:                    lead = 9999;
        endcase
    endfunction
    initial begin
        io1 = 1'b0;
        op = 8'h00;
        n = 0;
    end
    always @(negedge cs_n) n = 0;
    always @(posedge cs_n) io1 <= ~io1;
    always @(posedge sck) begin
        if (!cs_n) begin
            if (n < 8) op = {op[6:0], io0};
            n = n + 1;
        end
    end
    always @(negedge sck) begin
        k = n - lead(op);
        b = 8'hA0 + k[7:0] / 8'h08;
        if (cs_n || n < 8) io1 <= ~io1;
        else if (op == 8'h25) io1 <= 1'b1;
        else if (k >= 0) io1 <= b[7 - k % 8];
        else io1 <= ~io1;
    end
endmodule

// ===== testbench/test_flash_protect_status_cmd_decoder.sv
/* Self-checking bench for flash_cmd_host with flash_dev_model.
   Assumes hdl/ on the include path. */
`timescale 1ns/100ps
module test_flash_protect_status_cmd_decoder;
    reg        clk, rst_n, cmd_valid;
    reg [7:0]  cmd_op, cmd_len, cmd_dummy, wr_data, cur_op, sh, op_seen;
    reg [23:0] cmd_addr;
    reg [87:0] lst;
    wire       cmd_ready, wr_take, rd_valid, busy_level, done, bad_cmd, cs_n, sck, so;
    wire       o0, e0, o1, e1, o2, e2, o3, e3;
    wire       si = e0 ? o0 : ~o0;
    wire [7:0] rd_data;
    integer    err_count, checked, clocks, n_wr, n_rd, j;
    flash_cmd_host dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_dummy(cmd_dummy), .cmd_ready(cmd_ready),
        .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
        .busy_level(busy_level), .done(done), .bad_cmd(bad_cmd), .cs_n(cs_n), .sck(sck),
        .io0_out(o0), .io0_oe(e0), .io0_in(si), .io1_out(o1), .io1_oe(e1),
        .io1_in(e1 ? o1 : so), .io2_out(o2), .io2_oe(e2), .io2_in(e2 ? o2 : ~o2),
        .io3_out(o3), .io3_oe(e3), .io3_in(e3 ? o3 : ~o3));
    flash_dev_model dev (.cs_n(cs_n), .sck(sck), .io0(si), .io1(so));
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        begin
            $display("checked=%0d err_count=%0d", checked, err_count);
            if (err_count == 0 && checked > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            checked = checked + 1;
            if (e !== g) begin
                err_count = err_count + 1;
                $display("ERROR %s expected %0h seen %0h", nm, e, g);
            end
        end
    endtask
    always @(posedge sck) begin
        clocks = clocks + 1;
        sh = {sh[6:0], si};
        if (clocks == 8) op_seen = sh;
    end
    always @(negedge clk) begin
        if (wr_take === 1'b1) n_wr = n_wr + 1;
        if (rd_valid === 1'b1) begin
            if (cur_op != 8'h94) chk("rd_data", 8'hA0 + n_rd, rd_data);
            n_rd = n_rd + 1;
        end
    end
    // One request, then frame length, opcode, byte counts and last host byte
    task go(input [7:0] op, input [23:0] a, input [7:0] ln, input [7:0] dm,
            input integer ec, input integer ew, input integer er);
        integer i;
        begin
            for (i = 0; i < 100 && cmd_ready !== 1'b1; i = i + 1) @(negedge clk);
            if (i == 100) begin
                err_count = err_count + 1;
                final_report;
            end
            clocks = 0;
            n_wr = 0;
            n_rd = 0;
            cur_op = op;
            cmd_op = op;
            cmd_addr = a;
            cmd_len = ln;
            cmd_dummy = dm;
            cmd_valid = 1'b1;
            @(negedge clk);
            cmd_valid = 1'b0;
            for (i = 0; i < 20000 && done !== 1'b1; i = i + 1) @(negedge clk);
            if (i == 20000) begin
                err_count = err_count + 1;
                final_report;
            end
            @(negedge clk);
            chk("clocks", ec, clocks);
            chk("opcode", op, op_seen);
            chk("wr_take", ew, n_wr);
            chk("rd_valid", er, n_rd);
            if (ew > 0) chk("wr_byte", wr_data, sh);
        end
    endtask
    task t_cmd_only;
        begin
            lst = 88'h06_0450_7E98_B979_6699_EFAB;
            for (j = 0; j < 11; j = j + 1) go(lst[87 - 8 * j -: 8], 0, 0, 0, 8, 0, 0);
            go(8'h36, 24'h12_3456, 0, 0, 32, 0, 0);
            go(8'h39, 24'h00_0001, 0, 0, 32, 0, 0);
            go(8'hB9, 0, 0, 0, 8, 0, 0);
        end
    endtask
    task t_reads;
        begin
            go(8'h3C, 0, 1, 0, 40, 0, 1);
            go(8'h3D, 0, 1, 0, 40, 0, 1);
            go(8'h4B, 0, 3, 0, 64, 0, 3);
            go(8'h05, 0, 1, 0, 16, 0, 1);
            go(8'h35, 0, 1, 0, 16, 0, 1);
            go(8'h15, 0, 1, 0, 16, 0, 1);
            go(8'h65, 24'h00_0002, 1, 0, 32, 0, 1);
            go(8'h65, 24'h00_0001, 6, 0, 72, 0, 6);
            go(8'h90, 0, 2, 0, 48, 0, 2);
            go(8'h9F, 0, 5, 0, 48, 0, 5);
            go(8'h5A, 0, 4, 0, 72, 0, 4);
            go(8'hAB, 0, 1, 0, 40, 0, 1);
        end
    endtask
    task t_writes;
        begin
            go(8'h9B, 0, 8'h80, 0, 1056, 128, 0);
            go(8'h01, 0, 1, 0, 16, 1, 0);
            go(8'h31, 0, 1, 0, 16, 1, 0);
            go(8'h11, 0, 1, 0, 16, 1, 0);
            go(8'h71, 24'h00_0004, 1, 0, 24, 1, 0);
            go(8'h6F, 0, 2, 0, 24, 2, 0);
            go(8'hF0, 0, 1, 0, 16, 1, 0);
            go(8'h0A, 0, 3, 0, 56, 3, 0);
        end
    endtask
    task t_special;
        begin
            go(8'h94, 0, 2, 0, 20, 0, 2);
            go(8'h25, 0, 0, 2, 24, 0, 0);
            chk("busy_level", 1, busy_level);
            for (j = 0; j < 100 && cmd_ready !== 1'b1; j = j + 1) @(negedge clk);
            if (j == 100) begin
                err_count = err_count + 1;
                final_report;
            end
            clocks = 0;
            cmd_op = 8'h00;
            cmd_valid = 1'b1;
            @(negedge clk);
            cmd_valid = 1'b0;
            chk("bad_cmd", 1, bad_cmd);
            repeat (40) @(negedge clk);
            chk("bad_clocks", 0, clocks);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst_n, cmd_valid, cmd_op, cmd_len, cmd_dummy, cmd_addr} = 0;
        {err_count, checked, clocks, n_wr, n_rd} = 0;
        wr_data = 8'h5A;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_cmd_only;
        t_reads;
        t_writes;
        t_special;
        final_report;
    end
endmodule
